// ---- rtl/cam_map.svh ----
// Notes on behaviour
// - Non-cyclic: cam motion ends once master reaches either profile end point.
// - Non-cyclic: an external jump event ends cam motion early.
// - Linear cyclic: profile repeats until exit; slave end equals slave start.
// - Linear cyclic: master wraps at end points, slave never wraps.
// - Circular cyclic: repeats until exit; master and slave both wrap.
// - Profile is sectors of points, each with curve order 1, 2 or 3.
// - Every segment between adjacent points has its own coefficient set.
// - Curve passes exactly through each user point.
// - Slave is A*d^3 + B*d^2 + C*d + segment start slave.
// - Between points n-1 and n, point n-1 data is used.
// - Order 2 forces A to zero; order 1 forces A and B to zero.
// - Cyclic exit flag ends motion at the end of the current cycle.
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH
`define CAM_POINTS 16
`define CAM_IDX_W 4
`define CAM_IDX_FIRST 4'h0
`define CAM_IDX_ONE 4'h1
`define CAM_POS_W 32
`define CAM_ACC_W 96
`define CAM_FRAC 16
`define CAM_FLAGS 32
`define CAM_SEL_W 5
`define CAM_ORDER_LINEAR 2'h1
`define CAM_ORDER_QUAD 2'h2
`define CAM_ORDER_CUBIC 2'h3
`endif

// ---- rtl/cam_pkg.sv ----
`include "cam_map.svh"
package cam_pkg;
  typedef enum logic [1:0] {
    NON_CYCLIC = 2'h0,
    LINEAR_CYCLIC = 2'h1,
    CIRCULAR_CYCLIC = 2'h2
  } profile_kind_type;
  typedef enum logic [1:0] {
    EXIT_NONE = 2'h0,
    EXIT_BOUNDARY = 2'h1,
    EXIT_EVENT = 2'h2,
    EXIT_FLAG = 2'h3
  } exit_cause_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_SEARCH = 4'h4,
    ST_EVAL = 4'h8
  } state_type;
  typedef struct packed {
    logic signed [`CAM_POS_W-1:0] master;
    logic signed [`CAM_POS_W-1:0] slave;
    logic signed [`CAM_POS_W-1:0] coef_a;
    logic signed [`CAM_POS_W-1:0] coef_b;
    logic signed [`CAM_POS_W-1:0] coef_c;
    logic [1:0] order;
  } cam_point_type;
  typedef struct packed {
    profile_kind_type kind;
    logic [`CAM_IDX_W-1:0] last_index;
    logic exit_enable;
    logic [`CAM_SEL_W-1:0] exit_select;
  } cam_config_type;
endpackage

// ---- rtl/cam_segment_poly.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cam_map.svh"
module cam_segment_poly (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic eval,
  input wire cam_pkg::cam_point_type seg_point,
  input wire logic signed [`CAM_POS_W-1:0] master_pos,
  output logic signed [`CAM_POS_W-1:0] result,
  output logic done
);
  localparam int EXT = `CAM_ACC_W - `CAM_POS_W;
  // Offset must stay below 2^21 so the cube fits the accumulator
  logic signed [`CAM_POS_W-1:0] diff;
  logic signed [`CAM_ACC_W-1:0] d_w, a_w, b_w, c_w, sum, scaled;
  logic signed [`CAM_ACC_W-1:0] lin_sum, lin_scaled;
  logic signed [`CAM_POS_W-1:0] result_next, linear_value;
  logic is_cubic, has_square;
  assign diff = master_pos - seg_point.master;
  assign d_w = {{EXT{diff[`CAM_POS_W-1]}}, diff};
  assign is_cubic = seg_point.order == `CAM_ORDER_CUBIC;
  assign has_square = is_cubic || seg_point.order == `CAM_ORDER_QUAD;
  assign a_w = is_cubic ? {{EXT{seg_point.coef_a[`CAM_POS_W-1]}},
    seg_point.coef_a} : '0;
  assign b_w = has_square ? {{EXT{seg_point.coef_b[`CAM_POS_W-1]}},
    seg_point.coef_b} : '0;
  assign c_w = {{EXT{seg_point.coef_c[`CAM_POS_W-1]}}, seg_point.coef_c};
  assign sum = a_w * d_w * d_w * d_w + b_w * d_w * d_w + c_w * d_w;
  assign scaled = sum >>> `CAM_FRAC;
  // Zero offset leaves only the stored slave value
  assign result_next = scaled[`CAM_POS_W-1:0] + seg_point.slave;
  assign lin_sum = c_w * d_w;
  assign lin_scaled = lin_sum >>> `CAM_FRAC;
  assign linear_value = lin_scaled[`CAM_POS_W-1:0] + seg_point.slave;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
      done <= 1'b0;
    end else begin
      done <= eval;
      if (eval) begin
        result <= result_next;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  pass_point_a: assert property (
    eval && diff == '0 |=> done && result == $past(seg_point.slave))
    else $error("Curve misses the user point");
  linear_zero_a: assert property (
    eval && seg_point.order == `CAM_ORDER_LINEAR
    |=> result == $past(linear_value))
    else $error("First order segment uses higher terms");
  poly_latency_a: assert property (
    eval |=> done ##1 !done || $past(eval))
    else $error("Segment result timing wrong");
endmodule // cam_segment_poly
`default_nettype wire

// ---- rtl/cam_profile_evaluator.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cam_map.svh"
module cam_profile_evaluator (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic point_write,
  input wire logic [`CAM_IDX_W-1:0] point_index,
  input wire cam_pkg::cam_point_type point_data,
  input wire cam_pkg::cam_config_type config_in,
  input wire logic start,
  input wire logic master_valid,
  input wire logic signed [`CAM_POS_W-1:0] master_position,
  input wire logic [`CAM_FLAGS-1:0] control_flag,
  input wire logic jump_event,
  output logic signed [`CAM_POS_W-1:0] slave_command,
  output logic slave_valid,
  output logic cam_active,
  output logic cam_done,
  output cam_pkg::exit_cause_type exit_cause
);
  function automatic logic signed [`CAM_POS_W-1:0] wrap_pos(
    input logic signed [`CAM_POS_W-1:0] v,
    input logic signed [`CAM_POS_W-1:0] lo,
    input logic signed [`CAM_POS_W-1:0] hi);
    logic signed [`CAM_POS_W-1:0] span;
    span = hi - lo;
    if (v >= hi) begin
      wrap_pos = v - span;
    end else if (v < lo) begin
      wrap_pos = v + span;
    end else begin
      wrap_pos = v;
    end
  endfunction

  // One entry per user point, each with its own segment coefficients
  cam_pkg::cam_point_type point_mem [0:`CAM_POINTS-1];

  cam_pkg::state_type state_reg, state_next;
  cam_pkg::cam_config_type cfg_reg;
  cam_pkg::exit_cause_type cause_reg, cause_next;
  logic [`CAM_IDX_W-1:0] seg_reg, seg_next;
  logic signed [`CAM_POS_W-1:0] master_reg, prev_master_reg;
  logic signed [`CAM_POS_W-1:0] slave_reg, slave_next;
  logic first_sample_reg, exit_pending_reg;
  logic eval_reg, eval_next;
  logic valid_reg, valid_next;
  logic done_reg, done_next;
  logic active_reg;

  cam_pkg::cam_point_type first_pt, last_pt, seg_pt, next_pt;
  logic [`CAM_IDX_W-1:0] next_idx;
  logic is_cyclic, is_circular;
  logic signed [`CAM_POS_W-1:0] master_span, half_span, step;
  logic signed [`CAM_POS_W-1:0] wrapped_master, sample_master;
  logic signed [`CAM_POS_W-1:0] slave_lo, slave_hi;
  logic signed [`CAM_POS_W-1:0] poly_result;
  logic poly_done;
  logic at_sample, rollover, boundary, flag_now, exit_armed;
  logic seg_below, advance, slave_up;

  assign first_pt = point_mem[`CAM_IDX_FIRST];
  assign last_pt = point_mem[cfg_reg.last_index];
  assign seg_pt = point_mem[seg_reg];
  assign next_idx = seg_reg + `CAM_IDX_ONE;
  assign next_pt = point_mem[next_idx];
  assign is_cyclic = cfg_reg.kind != cam_pkg::NON_CYCLIC;
  assign is_circular = cfg_reg.kind == cam_pkg::CIRCULAR_CYCLIC;
  assign at_sample = state_reg == cam_pkg::ST_WAIT && master_valid;

  // Master wraps into [first, last) for both cyclic kinds
  assign wrapped_master = wrap_pos(master_position, first_pt.master,
    last_pt.master);
  assign sample_master = is_cyclic ? wrapped_master : master_position;
  assign master_span = last_pt.master - first_pt.master;
  assign half_span = master_span >>> 1;
  assign step = sample_master - prev_master_reg;
  // A jump of more than half a cycle is taken as a rollover
  assign rollover = is_cyclic && !first_sample_reg &&
    (step > half_span || step < -half_span);
  // Starting on the first point is allowed; returning to it ends motion
  assign boundary = !is_cyclic && (master_position >= last_pt.master ||
    master_position < first_pt.master ||
    (master_position == first_pt.master && !first_sample_reg));
  assign flag_now = cfg_reg.exit_enable &&
    control_flag[cfg_reg.exit_select];
  assign exit_armed = exit_pending_reg || flag_now;
  assign seg_below = sample_master < seg_pt.master;
  // Stop one short of the last point so its data is never evaluated
  assign advance = next_idx < cfg_reg.last_index &&
    master_reg >= next_pt.master;

  assign slave_up = last_pt.slave > first_pt.slave;
  assign slave_lo = slave_up ? first_pt.slave : last_pt.slave;
  assign slave_hi = slave_up ? last_pt.slave : first_pt.slave;
  // Linear cyclic passes the curve straight through, without wrapping
  assign slave_next = is_circular ?
    wrap_pos(poly_result, slave_lo, slave_hi) : poly_result;

  cam_segment_poly poly_unit (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .eval(eval_reg),
    .seg_point(seg_pt),
    .master_pos(master_reg),
    .result(poly_result),
    .done(poly_done)
  );

  always_comb begin
    state_next = state_reg;
    seg_next = seg_reg;
    cause_next = cause_reg;
    done_next = 1'b0;
    eval_next = 1'b0;
    valid_next = 1'b0;
    case (state_reg)
      cam_pkg::ST_IDLE: begin
        if (start) begin
          state_next = cam_pkg::ST_WAIT;
          seg_next = `CAM_IDX_FIRST;
          cause_next = cam_pkg::EXIT_NONE;
        end
      end
      cam_pkg::ST_WAIT: begin
        if (master_valid) begin
          if (!is_cyclic && jump_event) begin
            state_next = cam_pkg::ST_IDLE;
            done_next = 1'b1;
            cause_next = cam_pkg::EXIT_EVENT;
          end else if (boundary) begin
            state_next = cam_pkg::ST_IDLE;
            done_next = 1'b1;
            cause_next = cam_pkg::EXIT_BOUNDARY;
          end else if (rollover && exit_armed) begin
            state_next = cam_pkg::ST_IDLE;
            done_next = 1'b1;
            cause_next = cam_pkg::EXIT_FLAG;
          end else begin
            state_next = cam_pkg::ST_SEARCH;
            if (rollover || seg_below) begin
              seg_next = `CAM_IDX_FIRST;
            end
          end
        end
      end
      cam_pkg::ST_SEARCH: begin
        if (advance) begin
          seg_next = next_idx;
        end else begin
          state_next = cam_pkg::ST_EVAL;
          eval_next = 1'b1;
        end
      end
      cam_pkg::ST_EVAL: begin
        if (poly_done) begin
          state_next = cam_pkg::ST_WAIT;
          valid_next = 1'b1;
        end
      end
      default: begin
        state_next = cam_pkg::ST_IDLE;
      end
    endcase
  end

  // Profile load is locked out while a cam is running
  always_ff @(posedge sys_clk) begin
    if (point_write && state_reg == cam_pkg::ST_IDLE) begin
      point_mem[point_index] <= point_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cam_pkg::ST_IDLE;
      seg_reg <= '0;
      cause_reg <= cam_pkg::EXIT_NONE;
      done_reg <= 1'b0;
      eval_reg <= 1'b0;
      valid_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      seg_reg <= seg_next;
      cause_reg <= cause_next;
      done_reg <= done_next;
      eval_reg <= eval_next;
      valid_reg <= valid_next;
      active_reg <= state_next != cam_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= '0;
      first_sample_reg <= 1'b1;
      master_reg <= '0;
      prev_master_reg <= '0;
    end else if (state_reg == cam_pkg::ST_IDLE && start) begin
      cfg_reg <= config_in;
      first_sample_reg <= 1'b1;
    end else if (at_sample) begin
      first_sample_reg <= 1'b0;
      master_reg <= sample_master;
      prev_master_reg <= sample_master;
    end
  end

  // Flag is remembered until the cycle ends; any cycle in the idle state clears it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exit_pending_reg <= 1'b0;
    end else if (state_reg == cam_pkg::ST_IDLE) begin
      exit_pending_reg <= 1'b0;
    end else if (is_cyclic && flag_now) begin
      exit_pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_reg <= '0;
    end else if (state_reg == cam_pkg::ST_EVAL && poly_done) begin
      slave_reg <= slave_next;
    end
  end

  assign slave_command = slave_reg;
  assign slave_valid = valid_reg;
  assign cam_active = active_reg;
  assign cam_done = done_reg;
  assign exit_cause = cause_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  end_at_bound_a: assert property (
    at_sample && !is_cyclic && !jump_event &&
    master_position >= last_pt.master
    |=> cam_done && exit_cause == cam_pkg::EXIT_BOUNDARY && !cam_active)
    else $error("Non-cyclic cam ran past its end point");
  jump_exit_a: assert property (
    at_sample && !is_cyclic && jump_event
    |=> cam_done && exit_cause == cam_pkg::EXIT_EVENT)
    else $error("Jump event did not end the cam");
  no_early_exit_a: assert property (
    at_sample && is_cyclic && !rollover |=> !cam_done ##1 !cam_done)
    else $error("Cyclic cam left before the cycle ended");
  flag_at_wrap_a: assert property (
    cam_done && exit_cause == cam_pkg::EXIT_FLAG
    |-> $past(exit_armed) && $past(rollover))
    else $error("Flag exit outside a cycle end");
  master_wrap_a: assert property (
    state_reg == cam_pkg::ST_EVAL && is_cyclic
    |-> master_reg >= first_pt.master && master_reg < last_pt.master)
    else $error("Cyclic master not wrapped");
  slave_wrap_a: assert property (
    state_reg == cam_pkg::ST_EVAL && poly_done && is_circular
    |=> slave_command >= slave_lo && slave_command < slave_hi)
    else $error("Circular slave not wrapped");
  linear_nowrap_a: assert property (
    state_reg == cam_pkg::ST_EVAL && poly_done && !is_circular
    |=> slave_valid && slave_command == $past(poly_result))
    else $error("Linear slave was altered");
  seg_select_a: assert property (
    eval_reg |-> master_reg >= seg_pt.master &&
    (next_idx >= cfg_reg.last_index || master_reg < next_pt.master))
    else $error("Wrong segment chosen");
  wrap_restart_a: assert property (
    at_sample && rollover && !exit_armed
    |=> seg_reg == `CAM_IDX_FIRST && state_reg == cam_pkg::ST_SEARCH)
    else $error("Segment lookup not restarted on wrap");
endmodule // cam_profile_evaluator
`default_nettype wire

// ---- verification/cam_axis_model.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cam_map.svh"
module cam_axis_model (
  input wire logic sys_clk,
  input wire logic signed [`CAM_POS_W-1:0] slave_command,
  input wire logic slave_valid,
  input wire logic cam_done,
  output var logic master_valid,
  output var logic signed [`CAM_POS_W-1:0] master_position,
  output var logic jump_event
);
  initial begin
    master_valid = 1'b0;
    master_position = 32'h0;
    jump_event = 1'b0;
  end
  // One sample at a time: the evaluator drops samples while one is in flight
  task automatic send(input logic signed [`CAM_POS_W-1:0] pos,
      input logic jump, output logic signed [`CAM_POS_W-1:0] got,
      output logic fin, output logic hung);
    int n;
    got = slave_command;
    fin = 1'b0;
    hung = 1'b1;
    @(posedge sys_clk);
    master_valid <= 1'b1;
    master_position <= pos;
    jump_event <= jump;
    // Looking starts at the sample edge, as an exit pulse stands only then
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (n == 0) begin
        master_valid <= 1'b0;
        // Inverted value when idle, so a sample taken late cannot pass
        master_position <= ~pos;
        jump_event <= 1'b0;
      end
      #1;
      if (slave_valid === 1'b1 || cam_done === 1'b1) begin
        got = slave_command;
        fin = cam_done;
        hung = 1'b0;
        break;
      end
    end
  endtask
endmodule // cam_axis_model
`default_nettype wire

// ---- verification/electronic_cam_profile_evaluator_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cam_map.svh"
module electronic_cam_profile_evaluator_bench;
  logic sys_clk, rst_n, point_write, start, jump_event;
  logic master_valid, slave_valid, cam_active, cam_done;
  logic [`CAM_IDX_W-1:0] point_index;
  logic [`CAM_FLAGS-1:0] control_flag;
  logic signed [`CAM_POS_W-1:0] master_position, slave_command;
  cam_pkg::cam_point_type point_data;
  cam_pkg::cam_config_type cfg;
  cam_pkg::exit_cause_type exit_cause;
  int error_cnt, compares;

  cam_profile_evaluator uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .point_write(point_write), .point_index(point_index),
    .point_data(point_data), .config_in(cfg), .start(start),
    .master_valid(master_valid), .master_position(master_position),
    .control_flag(control_flag), .jump_event(jump_event),
    .slave_command(slave_command), .slave_valid(slave_valid),
    .cam_active(cam_active), .cam_done(cam_done), .exit_cause(exit_cause));
  cam_axis_model axis (.sys_clk(sys_clk), .slave_command(slave_command),
    .slave_valid(slave_valid), .cam_done(cam_done),
    .master_valid(master_valid), .master_position(master_position),
    .jump_event(jump_event));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_val(input string name,
      input logic signed [31:0] exp, input logic signed [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic check_flag(input string name, input logic exp,
      input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_cause(input string name,
      input cam_pkg::exit_cause_type exp, input cam_pkg::exit_cause_type got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // Coefficients are whole numbers in Q16.16, so no rounding is in play
  task automatic load(input logic [3:0] idx, input int m, s, a, b, c,
      input logic [1:0] ord);
    @(posedge sys_clk);
    point_write <= 1'b1;
    point_index <= idx;
    point_data <= '{master: m, slave: s, coef_a: a <<< 16,
      coef_b: b <<< 16, coef_c: c <<< 16, order: ord};
  endtask

  task automatic load_end();
    @(posedge sys_clk);
    point_write <= 1'b0;
  endtask

  task automatic set_flags(input logic [31:0] v);
    @(posedge sys_clk);
    control_flag <= v;
  endtask

  task automatic begin_cam(input cam_pkg::profile_kind_type kind,
      input logic [4:0] sel);
    @(posedge sys_clk);
    cfg <= '{kind: kind, last_index: 4'h3, exit_enable: 1'b1,
      exit_select: sel};
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    check_flag("cam_active", 1'b1, cam_active);
    check_cause("exit_cause", cam_pkg::EXIT_NONE, exit_cause);
  endtask

  task automatic sample(input int pos, input logic jump, input int expv,
      input logic done_exp);
    logic signed [`CAM_POS_W-1:0] got;
    logic fin, hung;
    axis.send(pos, jump, got, fin, hung);
    if (hung) begin
      error_cnt++;
      $display("unexpected answer expected 1 seen 0");
      print_verdict();
    end
    check_flag("cam_done", done_exp, fin);
    if (!done_exp) check_val("slave_command", expv, got);
  endtask

  task automatic non_cyclic_run();
    begin_cam(cam_pkg::NON_CYCLIC, 5'h0);
    sample(32'sh0, 1'b0, 32'sh64, 1'b0);
    sample(32'sh8, 1'b0, 32'sh74, 1'b0);
    load(4'h1, 32'sh10, 32'sh3e7, 32'sh0, 32'sh1, 32'sh0, 2'h2);
    load_end();
    sample(32'sh14, 1'b0, 32'sh94, 1'b0);
    sample(32'sh28, 1'b0, 32'sh384, 1'b0);
    sample(32'sh10, 1'b0, 32'sh84, 1'b0);
    sample(32'sh30, 1'b0, 32'sh0, 1'b1);
    check_cause("exit_cause", cam_pkg::EXIT_BOUNDARY, exit_cause);
    check_flag("cam_active", 1'b0, cam_active);
  endtask

  task automatic jump_run();
    begin_cam(cam_pkg::NON_CYCLIC, 5'h0);
    sample(32'sh5, 1'b0, 32'sh6e, 1'b0);
    sample(32'sh6, 1'b1, 32'sh0, 1'b1);
    check_cause("exit_cause", cam_pkg::EXIT_EVENT, exit_cause);
  endtask

  task automatic linear_run();
    // Last segment falls back to the start slave value
    load(4'h2, 32'sh20, 32'sh184, 32'sh0, 32'sh0, -32'sh12, 2'h1);
    load(4'h3, 32'sh30, 32'sh64, 32'sh0, 32'sh0, 32'sh0, 2'h1);
    load_end();
    begin_cam(cam_pkg::LINEAR_CYCLIC, 5'h3);
    sample(32'sha, 1'b0, 32'sh78, 1'b0);
    sample(32'sh1e, 1'b0, 32'sh148, 1'b0);
    sample(32'sh28, 1'b0, 32'shf4, 1'b0);
    set_flags(32'h1);
    sample(32'sh32, 1'b0, 32'sh68, 1'b0);
    check_flag("cam_active", 1'b1, cam_active);
    set_flags(32'h8);
    sample(32'sh14, 1'b0, 32'sh94, 1'b0);
    sample(32'sh1e, 1'b0, 32'sh148, 1'b0);
    sample(32'sh34, 1'b0, 32'sh0, 1'b1);
    check_cause("exit_cause", cam_pkg::EXIT_FLAG, exit_cause);
    set_flags(32'h0);
  endtask

  task automatic circular_run();
    // Monotonic cubic keeps every value between first and last slave
    load(4'h2, 32'sh20, 32'sh184, 32'sh1, 32'sh0, 32'sh0, 2'h3);
    load(4'h3, 32'sh30, 32'sh1184, 32'sh0, 32'sh0, 32'sh0, 2'h1);
    load_end();
    begin_cam(cam_pkg::CIRCULAR_CYCLIC, 5'h1f);
    sample(32'sh28, 1'b0, 32'sh384, 1'b0);
    sample(32'sh32, 1'b0, 32'sh68, 1'b0);
    sample(32'sh14, 1'b0, 32'sh94, 1'b0);
    sample(32'sh1e, 1'b0, 32'sh148, 1'b0);
    set_flags(32'h80000000);
    sample(32'sh31, 1'b0, 32'sh0, 1'b1);
    check_cause("exit_cause", cam_pkg::EXIT_FLAG, exit_cause);
  endtask

  initial begin
    rst_n = 1'b0;
    point_write = 1'b0;
    start = 1'b0;
    point_index = 4'h0;
    point_data = '0;
    cfg = '0;
    control_flag = 32'h0;
    error_cnt = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    check_flag("cam_active", 1'b0, cam_active);
    check_flag("slave_valid", 1'b0, slave_valid);
    check_cause("exit_cause", cam_pkg::EXIT_NONE, exit_cause);
    rst_n <= 1'b1;
    // Order 1 and 2 points carry stray coefficients that must be ignored
    load(4'h0, 32'sh0, 32'sh64, 32'sh1, 32'sh1, 32'sh2, 2'h1);
    load(4'h1, 32'sh10, 32'sh84, 32'sh5, 32'sh1, 32'sh0, 2'h2);
    load(4'h2, 32'sh20, 32'sh184, 32'sh1, 32'sh0, 32'sh0, 2'h3);
    load(4'h3, 32'sh30, 32'sh1184, 32'sh0, 32'sh0, 32'sh0, 2'h1);
    load_end();
    non_cyclic_run();
    jump_run();
    linear_run();
    circular_run();
    print_verdict();
  end
endmodule // electronic_cam_profile_evaluator_bench
`default_nettype wire
